// >>> inc/dbmc_map.svh
`ifndef DBMC_MAP_SVH
`define DBMC_MAP_SVH
// ----------------------------------------
// port addresses
// ----------------------------------------
`define DBMC_OFS_MEMCTL 16'h3872
`define DBMC_OFS_START01 16'h4872
`define DBMC_OFS_START23 16'h5072
`define DBMC_OFS_SPLIT 16'h5872
`define DBMC_OFS_SHADOW 16'h6072
`define DBMC_OFS_HMBOUND 16'hC072
// ----------------------------------------
// reset values
// ----------------------------------------
`define DBMC_RST_WORD 16'h0000
`define DBMC_RST_BYTE 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define DBMC_PG_BIT 11
`define DBMC_ILV_LSB 8
`define DBMC_BANK_ON_LSB 12
`define DBMC_DRV_LSB 10
`define DBMC_SPSZ_LSB 8
`define DBMC_SPADR_LSB 2
`define DBMC_LOWDIS_LSB 14
`define DBMC_HMWP_BIT 13
`define DBMC_WP_BIT 12
`define DBMC_PFLIP_BIT 11
`define DBMC_SPLIT_KEEP 16'hFFFC
`define DBMC_SHADOW_KEEP 16'hFFBF
// ----------------------------------------
// interleave codes
// ----------------------------------------
`define DBMC_ILV_01 3'h1
`define DBMC_ILV_23 3'h2
`define DBMC_ILV_BOTH 3'h3
`define DBMC_ILV_FOUR 3'h4
// ----------------------------------------
// address map
// ----------------------------------------
`define DBMC_LOW_BASE 25'h00A0000
`define DBMC_SPLIT_LEN1 25'h0040000
`define DBMC_SPLIT_LEN2 25'h0050000
`define DBMC_SPLIT_LEN3 25'h0060000
`define DBMC_DIS_512K 25'h0080000
`define DBMC_DIS_256K 25'h0040000
`define DBMC_DIS_128K 25'h0020000
`define DBMC_SHADOW128 25'h00E0000
`define DBMC_SHADOW64 25'h00F0000
`define DBMC_MB1 25'h0100000
`define DBMC_PAGE_BIT0 5'h09
`define DBMC_WORD_BIT 5'h01
`endif

// >>> inc/dbmc_pkg.sv
package dbmc_pkg;
  // ----------------------------------------
  // memory request from the address path
  // ----------------------------------------
  typedef struct packed {
    logic [24:0] addr;
    logic wr;
  } dbmc_req_t;

  // ----------------------------------------
  // I/O port access
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } dbmc_io_t;
endpackage : dbmc_pkg

// >>> logic/dbmc_bank_match.sv
`timescale 1ns/10ps
module dbmc_bank_match (
  input wire logic on_i,
  input wire logic [7:0] start_i,
  input wire logic [1:0] size_i,
  input wire logic [1:0] ilv_shift_i,
  input wire logic [7:0] addr_hi_i,
  output logic hit_o
);
  // span in 128 KB units: 1, 4, 16 or 64, times the group factor
  logic [3:0] span_log;
  logic [8:0] span;
  logic [9:0] top;

  assign span_log = {1'b0, size_i, 1'b0} + {2'b00, ilv_shift_i}; // [RULE6] [RULE5]
  assign span = 9'h001 << span_log; // [RULE1]
  assign top = {2'b00, start_i} + {1'b0, span}; // [RULE2]
  // bit 17 granularity is enough since the smallest bank is 128 KB
  assign hit_o = on_i && (addr_hi_i >= start_i) && ({2'b00, addr_hi_i} < top); // [RULE19]
endmodule : dbmc_bank_match

// >>> logic/dbmc_top.sv
`timescale 1ns/10ps
`include "dbmc_map.svh"
// Functional notes
// RULE1: two-bit part size per bank selects 64K, 256K, 1M or 4M by-16 parts.
// RULE2: eight-bit start address per bank holds A24..A17; two banks per register.
// RULE3: software aligns each bank start to a multiple of its size.
// RULE4: software puts smaller banks higher; an interleaved pair sits below a third.
// RULE5: interleaved group decodes as one region two or four times a bank.
// RULE6: part size gives 128K/512K/2M/8M capacity and 512..4096 byte pages.
// RULE7: one enable bit per bank, bits 15..12, gates its decoding; reset off. Interleaved, a bank 0 or 2 hit strobes its partners whatever their bits.
// RULE8: active split remaps the block above 640 KB to a 512 KB aligned area.
// RULE9: split size field picks none, 256 KB, 320 KB or 384 KB.
// RULE10: split destination is A24..A19 in bits 7..2; bits 1..0 ignored.
// RULE11: software splits only one bank, of at least 512 KB.
// RULE12: software picks 320 or 256 KB split for shadowing and sets shadow register.
// RULE13: two-bit field disables on-board memory from 512, 256 or 128 KB to 640 KB.
// RULE14: bit 13 enables write blocking above the high-memory boundary.
// RULE15: bit 12 blocks writes to the shadowed firmware region.
// RULE16: bit 11 inverts the parity written to on-board memory.
// RULE17: protected writes are blocked by withholding the column strobe.
// RULE18: high boundary is an eight-bit A24..A17 field; above it is protected.
// RULE19: enabled bank in range gets its row strobe, otherwise expansion bus.
// RULE20: reset loads every mapping and protection field with its default.
module dbmc_top (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire dbmc_pkg::dbmc_io_t IO_I,
  input wire logic MEM_CYC_I,
  input wire dbmc_pkg::dbmc_req_t MEM_REQ_I,
  output logic [15:0] IO_RDATA_O,
  output logic DEC_VLD_O,
  output logic [3:0] RAS_O,
  output logic CAS_EN_O,
  output logic EXP_BUS_O,
  output logic [24:0] PHYS_ADDR_O,
  output logic PAR_FLIP_O,
  output logic [1:0] ADDR_DRV_O
);
  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [15:0] memctl_r;
  logic [15:0] start01_r;
  logic [15:0] start23_r;
  logic [15:0] split_r;
  logic [15:0] shadow_r;
  logic [7:0] hmb_r;

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      memctl_r <= `DBMC_RST_WORD; // [RULE20] [RULE1]
      start01_r <= `DBMC_RST_WORD;
      start23_r <= `DBMC_RST_WORD;
      split_r <= `DBMC_RST_WORD; // [RULE7]
      shadow_r <= `DBMC_RST_WORD;
      hmb_r <= `DBMC_RST_BYTE;
    end
    else if (IO_I.wr)
    begin
      unique case (IO_I.addr)
        `DBMC_OFS_MEMCTL: memctl_r <= IO_I.wdata;
        `DBMC_OFS_START01: start01_r <= IO_I.wdata; // [RULE2]
        `DBMC_OFS_START23: start23_r <= IO_I.wdata;
        `DBMC_OFS_SPLIT: split_r <= IO_I.wdata & `DBMC_SPLIT_KEEP; // [RULE10]
        `DBMC_OFS_SHADOW: shadow_r <= IO_I.wdata & `DBMC_SHADOW_KEEP;
        `DBMC_OFS_HMBOUND: hmb_r <= IO_I.wdata[7:0]; // [RULE18]
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // register read back
  // ----------------------------------------
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      IO_RDATA_O <= `DBMC_RST_WORD;
    else if (IO_I.rd)
    begin
      unique case (IO_I.addr)
        `DBMC_OFS_MEMCTL: IO_RDATA_O <= memctl_r;
        `DBMC_OFS_START01: IO_RDATA_O <= start01_r;
        `DBMC_OFS_START23: IO_RDATA_O <= start23_r;
        `DBMC_OFS_SPLIT: IO_RDATA_O <= split_r;
        `DBMC_OFS_SHADOW: IO_RDATA_O <= shadow_r;
        `DBMC_OFS_HMBOUND: IO_RDATA_O <= {8'h00, hmb_r};
        default: IO_RDATA_O <= `DBMC_RST_WORD;
      endcase
    end
  end

  // ----------------------------------------
  // field views
  // ----------------------------------------
  logic [2:0] ilv;
  logic pg;
  logic [3:0] bank_on;
  logic [1:0] sp_size;
  logic [24:0] sp_dest;
  logic [1:0] low_dis;
  logic high_mem_protect_on;
  logic wp;

  assign ilv = memctl_r[`DBMC_ILV_LSB +: 3];
  assign pg = memctl_r[`DBMC_PG_BIT];
  assign bank_on = split_r[`DBMC_BANK_ON_LSB +: 4]; // [RULE7]
  assign sp_size = split_r[`DBMC_SPSZ_LSB +: 2];
  assign sp_dest = {split_r[`DBMC_SPADR_LSB +: 6], 19'h00000}; // [RULE10] [RULE8]
  assign low_dis = shadow_r[`DBMC_LOWDIS_LSB +: 2];
  assign high_mem_protect_on = shadow_r[`DBMC_HMWP_BIT];
  assign wp = shadow_r[`DBMC_WP_BIT];

  // ----------------------------------------
  // split remap and disabled areas
  // ----------------------------------------
  logic [24:0] addr;
  logic [24:0] sp_len;
  logic in_dest;
  logic in_hole;
  logic low_off;
  logic [24:0] phys;

  assign addr = MEM_REQ_I.addr;

  always_comb
  begin
    unique case (sp_size) // [RULE9]
      2'h1: sp_len = `DBMC_SPLIT_LEN1;
      2'h2: sp_len = `DBMC_SPLIT_LEN2;
      2'h3: sp_len = `DBMC_SPLIT_LEN3;
      default: sp_len = 25'h0000000;
    endcase
  end

  assign in_dest = (sp_size != 2'h0) && (addr >= sp_dest) && (addr < sp_dest + sp_len); // [RULE8]
  // the vacated window is handed to the bus, never decoded twice
  assign in_hole = (sp_size != 2'h0) && (addr >= `DBMC_LOW_BASE) &&
                   (addr < `DBMC_LOW_BASE + sp_len); // [RULE9]
  assign phys = in_dest ? (addr - sp_dest + `DBMC_LOW_BASE) : addr; // [RULE8]

  always_comb
  begin
    unique case (low_dis) // [RULE13]
      2'h1: low_off = (addr >= `DBMC_DIS_512K) && (addr < `DBMC_LOW_BASE);
      2'h2: low_off = (addr >= `DBMC_DIS_256K) && (addr < `DBMC_LOW_BASE);
      2'h3: low_off = (addr >= `DBMC_DIS_128K) && (addr < `DBMC_LOW_BASE);
      default: low_off = 1'b0;
    endcase
  end

  // ----------------------------------------
  // bank decode
  // ----------------------------------------
  logic [3:0] hit;

  for (genvar i = 0; i < 4; i++)
  begin : g_bank
    logic [7:0] start;
    logic [1:0] shift;
    if (i < 2)
    begin : g_lo
      assign start = start01_r[8*i +: 8]; // [RULE2]
      assign shift = (ilv == `DBMC_ILV_FOUR) ? 2'h2 :
                     (ilv == `DBMC_ILV_01 || ilv == `DBMC_ILV_BOTH) ? 2'h1 : 2'h0; // [RULE5]
    end
    else
    begin : g_hi
      assign start = start23_r[8*(i-2) +: 8];
      assign shift = (ilv == `DBMC_ILV_FOUR) ? 2'h2 :
                     (ilv == `DBMC_ILV_23 || ilv == `DBMC_ILV_BOTH) ? 2'h1 : 2'h0;
    end
    dbmc_bank_match u_match (
      .on_i(bank_on[i]),
      .start_i(start),
      .size_i(memctl_r[2*i +: 2]),
      .ilv_shift_i(shift),
      .addr_hi_i(phys[24:17]),
      .hit_o(hit[i])
    );
  end

  // interleave steering: word bit in non-page mode, page bit in page mode
  logic [4:0] sb01;
  logic [4:0] sb23;
  logic [3:0] ras_nxt;

  assign sb01 = pg ? (`DBMC_PAGE_BIT0 + {3'h0, memctl_r[1:0]}) : `DBMC_WORD_BIT; // [RULE6]
  assign sb23 = pg ? (`DBMC_PAGE_BIT0 + {3'h0, memctl_r[5:4]}) : `DBMC_WORD_BIT;

  always_comb
  begin
    ras_nxt = 4'h0;
    if (in_hole || low_off)
      ras_nxt = 4'h0;
    else if (ilv == `DBMC_ILV_FOUR && hit[0])
      ras_nxt = 4'h1 << phys[sb01 +: 2]; // [RULE5]
    else if ((ilv == `DBMC_ILV_01 || ilv == `DBMC_ILV_BOTH) && hit[0])
      ras_nxt = 4'h1 << phys[sb01];
    else if ((ilv == `DBMC_ILV_23 || ilv == `DBMC_ILV_BOTH) && hit[2])
      ras_nxt = 4'h4 << phys[sb23];
    else if (hit[0])
      ras_nxt = 4'h1; // [RULE19]
    else if (hit[1])
      ras_nxt = 4'h2;
    else if (hit[2])
      ras_nxt = 4'h4;
    else if (hit[3])
      ras_nxt = 4'h8;
  end

  // ----------------------------------------
  // write protection
  // ----------------------------------------
  logic hm_block;
  logic sh_block;
  logic cas_nxt;

  assign hm_block = high_mem_protect_on && (addr[24:17] > hmb_r); // [RULE14] [RULE18]
  // shadow copy sits at the top of the first megabyte, just above the vacated split window
  assign sh_block = wp && (addr < `DBMC_MB1) &&
                    (((sp_size == 2'h1) && (addr >= `DBMC_SHADOW128)) ||
                     ((sp_size == 2'h2) && (addr >= `DBMC_SHADOW64))); // [RULE15]
  assign cas_nxt = !(MEM_REQ_I.wr && (hm_block || sh_block)); // [RULE17]

  // ----------------------------------------
  // registered decode outputs
  // ----------------------------------------
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      DEC_VLD_O <= 1'b0; // [RULE20]
      RAS_O <= 4'h0;
      CAS_EN_O <= 1'b1;
      EXP_BUS_O <= 1'b0;
      PHYS_ADDR_O <= 25'h0000000;
    end
    else
    begin
      DEC_VLD_O <= MEM_CYC_I;
      RAS_O <= MEM_CYC_I ? ras_nxt : 4'h0;
      CAS_EN_O <= MEM_CYC_I ? cas_nxt : 1'b1;
      EXP_BUS_O <= MEM_CYC_I && (ras_nxt == 4'h0); // [RULE19]
      PHYS_ADDR_O <= MEM_CYC_I ? phys : 25'h0000000;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      PAR_FLIP_O <= 1'b0;
      ADDR_DRV_O <= 2'h0;
    end
    else
    begin
      PAR_FLIP_O <= shadow_r[`DBMC_PFLIP_BIT]; // [RULE16]
      ADDR_DRV_O <= split_r[`DBMC_DRV_LSB +: 2];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  reset_defaults_a: assert property ( // [RULE20]
    $fell(SRST_I) |-> (split_r == 16'h0000 && shadow_r == 16'h0000 && memctl_r == 16'h0000)
  ) else $error("config not at default after reset");

  bank_gate_a: assert property ( // [RULE7]
    DEC_VLD_O |-> ((RAS_O & ~$past(bank_on)) == 4'h0)
  ) else $error("row strobe on a disabled bank");

  one_bank_a: assert property ( // [RULE19]
    $onehot0(RAS_O) && !(EXP_BUS_O && RAS_O != 4'h0)
  ) else $error("bank select not exclusive");

  high_protect_a: assert property ( // [RULE18]
    (MEM_CYC_I && MEM_REQ_I.wr && high_mem_protect_on && addr[24:17] > hmb_r) |=> !CAS_EN_O
  ) else $error("write above boundary not blocked");

  parity_flip_a: assert property ( // [RULE16]
    $changed(shadow_r[`DBMC_PFLIP_BIT]) |=> (PAR_FLIP_O == $past(shadow_r[`DBMC_PFLIP_BIT]))
  ) else $error("parity flip did not follow register");

  split_hole_a: assert property ( // [RULE9]
    (MEM_CYC_I && sp_size == 2'h1 && addr == `DBMC_LOW_BASE) |=> (EXP_BUS_O && RAS_O == 4'h0)
  ) else $error("split window still decoded on board");

  split_map_a: assert property ( // [RULE8]
    (MEM_CYC_I && sp_size != 2'h0 && addr == sp_dest) |=> (PHYS_ADDR_O == `DBMC_LOW_BASE)
  ) else $error("split destination not remapped");

  low_disable_a: assert property ( // [RULE13]
    (MEM_CYC_I && low_dis == 2'h3 && addr == `DBMC_DIS_128K) |=> EXP_BUS_O
  ) else $error("disabled low memory decoded on board");
endmodule : dbmc_top

// >>> test/dbmc_dram_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// dram array: counts writes that land
// ----------------------------------------
module dbmc_dram_model (
  input wire logic clk_i,
  input wire logic cyc_i,
  input wire logic wr_i,
  input wire logic vld_i,
  input wire logic [3:0] ras_i,
  input wire logic cas_en_i,
  output int landed_o
);
  logic wr_d = 1'b0;
  initial landed_o = 0;
  always @(posedge clk_i)
  begin
    wr_d <= cyc_i & wr_i;
    // no column strobe means the cell keeps its old data
    if (vld_i && wr_d && (ras_i != 4'h0) && cas_en_i)
      landed_o <= landed_o + 1;
  end
endmodule : dbmc_dram_model

// >>> test/dbmc_top_test.sv
`timescale 1ns/10ps
`include "dbmc_map.svh"
module dbmc_top_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  dbmc_pkg::dbmc_io_t io = '0;
  logic cyc = 1'b0;
  dbmc_pkg::dbmc_req_t req = '0;
  logic [15:0] rdata;
  logic vld, cas, expb, pflip;
  logic [3:0] ras;
  logic [24:0] phys;
  logic [1:0] drv;
  int err_count = 0;
  int cmp_count = 0;
  int wr_exp = 0;
  int landed, seed, on, spsz, dest, lowdis, hmwp, wp, bnd;
  int sz[4];
  int ilv = 0;
  int pgm = 0;
  int st[4];
  dbmc_top i_dut (.CLK_I(clk), .SRST_I(srst), .IO_I(io), .MEM_CYC_I(cyc), .MEM_REQ_I(req),
    .IO_RDATA_O(rdata), .DEC_VLD_O(vld), .RAS_O(ras), .CAS_EN_O(cas), .EXP_BUS_O(expb),
    .PHYS_ADDR_O(phys), .PAR_FLIP_O(pflip), .ADDR_DRV_O(drv));
  dbmc_dram_model i_dram (.clk_i(clk), .cyc_i(cyc), .wr_i(req.wr), .vld_i(vld), .ras_i(ras),
    .cas_en_i(cas), .landed_o(landed));
  always #50 clk = ~clk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      err_count++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic close_out();
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic io_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    io <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    io <= '0;
  endtask : io_wr
  task automatic io_rd(input logic [15:0] a, input logic [15:0] want);
    @(posedge clk);
    io <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
    @(posedge clk);
    io <= '0;
    @(negedge clk);
    check(rdata, want);
  endtask : io_rd
  task automatic model(input int a, input int w, output logic [3:0] r, output logic c,
    output logic [24:0] p);
    int len, pa, lo, k, sh;
    logic [3:0] h;
    len = (spsz == 0) ? 0 : 32'h40000 + (spsz - 1) * 32'h10000;
    pa = (a >= dest && a < dest + len) ? a - dest + 32'hA0000 : a;
    lo = (lowdis == 0) ? 32'hA0000 : (32'h100000 >> lowdis);
    r = 4'h0;
    for (k = 3; k >= 0; k--)
    begin
      // group factor: two for a pair, four for the four-way set
      sh = (ilv == 4) ? 2 : ((ilv == 3 || ilv == ((k < 2) ? 1 : 2)) ? 1 : 0);
      h[k] = on[k] && (pa >> 17) >= st[k] && (pa >> 17) < st[k] + (1 << (2 * sz[k] + sh));
      if (h[k])
        r = 4'h1 << k;
    end
    if (h[0] && ilv == 4)
      r = 4'h1 << ((pa >> (pgm ? 9 + sz[0] : 1)) & 3);
    else if (h[0] && (ilv == 1 || ilv == 3))
      r = 4'h1 << ((pa >> (pgm ? 9 + sz[0] : 1)) & 1);
    else if (h[2] && (ilv == 2 || ilv == 3))
      r = 4'h4 << ((pa >> (pgm ? 9 + sz[2] : 1)) & 1);
    if ((a >= 32'hA0000 && a < 32'hA0000 + len) || (a >= lo && a < 32'hA0000))
      r = 4'h0;
    c = !(w && ((hmwp && (a >> 17) > bnd) || (wp && a < 32'h100000 &&
      ((spsz == 1 && a >= 32'hE0000) || (spsz == 2 && a >= 32'hF0000)))));
    p = pa[24:0];
  endtask : model
  task automatic mem(input int a, input logic w);
    logic [3:0] r;
    logic c;
    logic [24:0] p;
    model(a, w, r, c, p);
    @(posedge clk);
    cyc <= 1'b1;
    req <= '{addr: a[24:0], wr: w};
    @(posedge clk);
    cyc <= 1'b0;
    @(negedge clk);
    check(vld, 32'h1);
    check(ras, r);
    check(expb, r == 4'h0);
    check(cas, c);
    check(phys, p);
    if (w && r != 4'h0 && c)
      wr_exp++;
  endtask : mem
  task automatic config_run();
    int base, s, k, j, a, pf, dv;
    logic [15:0] spl, shd, mc;
    base = 0;
    on = 0;
    j = -1;
    for (k = 0; k < 4; k++)
      sz[k] = $urandom_range(3);
    // largest first, packed upward: aligned, smaller higher
    for (s = 3; s >= 0; s--)
      for (k = 0; k < 4; k++)
        if (sz[k] == s)
        begin
          st[k] = base & 255;
          if (base + (1 << (2 * s)) <= 256)
          begin
            on[k] = $urandom_range(1);
            base += 1 << (2 * s);
            if (on[k] && s > 0 && st[k] > 0) j = k;
          end
        end
    // interleave: equal banks, whole group on, pair below the rest
    ilv = 0;
    pgm = $urandom_range(1);
    if ($urandom_range(1))
    begin
      ilv = $urandom_range(4, 1);
      s = (ilv == 4) ? 3 : $urandom_range(3, 1);
      pgm = (ilv == 4) ? 1 : pgm;
      j = -1;
      on = 15;
      for (k = 0; k < 4; k++)
      begin
        sz[k] = s;
        st[k] = (ilv == 4) ? 0 : (ilv == 1) ? ((k < 2) ? 0 : k << (2 * s)) :
          (ilv == 2) ? ((k < 2) ? (k + 2) << (2 * s) : 0) : ((k < 2) ? 0 : 2 << (2 * s));
      end
    end
    // one split bank of 512 KB or more
    spsz = (j < 0) ? 0 : $urandom_range(3);
    dest = (j < 0) ? 0 : st[j] << 17;
    lowdis = $urandom_range(3);
    hmwp = $urandom_range(1);
    wp = $urandom_range(1);
    bnd = $urandom_range(255);
    pf = $urandom_range(1);
    dv = $urandom_range(3);
    spl = 16'((on << 12) | (dv << 10) | (spsz << 8) | ((dest >> 19) << 2) | $urandom_range(3));
    shd = 16'((lowdis << 14) | (hmwp << 13) | (wp << 12) | (pf << 11) | $urandom_range(16'h07FF));
    mc = 16'((pgm << 11) | (ilv << 8) | (sz[3] << 6) | (sz[2] << 4) | (sz[1] << 2) | sz[0]);
    io_wr(`DBMC_OFS_MEMCTL, mc);
    io_wr(`DBMC_OFS_START01, 16'((st[1] << 8) | st[0]));
    io_wr(`DBMC_OFS_START23, 16'((st[3] << 8) | st[2]));
    io_wr(`DBMC_OFS_SPLIT, spl);
    io_wr(`DBMC_OFS_SHADOW, shd);
    io_wr(`DBMC_OFS_HMBOUND, 16'(bnd));
    io_rd(`DBMC_OFS_START23, 16'((st[3] << 8) | st[2]));
    io_rd(`DBMC_OFS_SPLIT, spl & 16'hFFFC);
    io_rd(`DBMC_OFS_MEMCTL, mc);
    io_rd(`DBMC_OFS_SHADOW, shd & 16'hFFBF);
    check(pflip, pf);
    check(drv, dv);
    for (k = 0; k < 40; k++)
    begin
      s = $urandom_range(3);
      if (s == 0) a = $urandom_range(32'hFFFFF);
      else if (s == 1) a = dest + $urandom_range(32'h70000);
      else if (s == 2) a = (st[$urandom_range(3)] << 17) + $urandom_range(32'h1FFFF);
      else a = $urandom & 32'h1FFFFFF;
      mem(a, $urandom_range(1));
    end
    mem(dest, 1'b0);
    mem(32'hA0000, 1'b1);
    mem(32'h20000, 1'b1);
    @(negedge clk);
    check(vld, 32'h0);
  endtask : config_run
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    seed = $urandom(39);
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check({vld, ras, rdata}, 32'h0);
    check({cas, expb, pflip, drv, phys}, 32'h1 << 29);
    io_rd(`DBMC_OFS_MEMCTL, 16'h0000);
    io_rd(`DBMC_OFS_START01, 16'h0000);
    io_rd(`DBMC_OFS_SPLIT, 16'h0000);
    io_rd(`DBMC_OFS_SHADOW, 16'h0000);
    io_rd(16'h1234, 16'h0000);
    io_wr(`DBMC_OFS_HMBOUND, 16'hFFFF);
    io_rd(`DBMC_OFS_HMBOUND, 16'h00FF);
    repeat (40) config_run();
    repeat (3) @(negedge clk);
    check(landed, wr_exp);
    // second reset after all runs, over the last random configuration
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check({vld, ras, rdata}, 32'h0);
    check({cas, expb, pflip, drv, phys}, 32'h1 << 29);
    io_rd(`DBMC_OFS_SPLIT, 16'h0000);
    io_rd(`DBMC_OFS_HMBOUND, 16'h0000);
    close_out();
  end
  initial
  begin
    #3000000;
    err_count++;
    close_out();
  end
endmodule : dbmc_top_test
